// File: sramc_consts.svh
// Timing counts and widths for the static memory host controller
`ifndef SRAMC_CONSTS_SVH
`define SRAMC_CONSTS_SVH

`define SRAMC_CLK_PERIOD_NS  5
`define SRAMC_ADDR_W         10
`define SRAMC_DATA_W         4
`define SRAMC_DEPTH          1024
// Speed grade timings in ns (fastest grade by default)
`define SRAMC_ACCESS_NS      200
`define SRAMC_WRITE_WIN_NS   100
`define SRAMC_OVERLAP_NS     100
`define SRAMC_RELEASE_NS     20
`define SRAMC_RELEASE_Z_NS   40
// Cycle counts: least times round up
`define SRAMC_ACCESS_CYC     ((`SRAMC_ACCESS_NS + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_WRITE_WIN_CYC  ((`SRAMC_WRITE_WIN_NS + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_OVERLAP_CYC    ((`SRAMC_OVERLAP_NS + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_RELEASE_CYC    ((`SRAMC_RELEASE_NS + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_RELEASE_Z_CYC  ((`SRAMC_RELEASE_Z_NS + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_CNT_W          8

`endif

// File: sramc_host.sv
// Host controller that reads and writes a 1K by 4 asynchronous static memory
`timescale 1ns/1ps
`default_nettype none
`include "sramc_consts.svh"

// Contract
// - Host keeps strobe high during address changes.
// - Host holds address through window plus release.
// - New address no later than window opening.
// - Host holds data overlap time before close.
// - Window from later fall to strobe rise.
// - Cycle equals access time, no address setup.
module sramc_host
	import sramc_pkg::*;
(
	input  wire logic                       clock,        // System clock
	input  wire logic                       sys_rst,      // Synchronous reset, active high
	input  wire logic                       req_valid,    // Access request
	output logic                            req_ready,    // Request taken when both high
	input  wire logic                       req_write,    // High for write, low for read
	input  wire logic [`SRAMC_ADDR_W-1:0]   req_addr,     // Word address
	input  wire logic [`SRAMC_DATA_W-1:0]   req_wdata,    // Write data
	output logic                            rsp_valid,    // One-cycle read data pulse
	output logic [`SRAMC_DATA_W-1:0]        rsp_rdata,    // Read data
	output logic                            done_pulse,   // One-cycle completion of any access
	output logic [`SRAMC_ADDR_W-1:0]        word_addr,    // Address pins to memory
	output logic                            select_n,     // Active-low select pin
	output logic                            write_n,      // Active-low write strobe pin
	input  wire logic [`SRAMC_DATA_W-1:0]   shared_data_pins_i,  // Data pins as seen
	output logic [`SRAMC_DATA_W-1:0]        shared_data_pins_o,  // Data driven to pins
	output logic                            shared_data_pins_oe  // High while host drives pins
);

	sramc_state_e                  state_q;        // Access sequencer
	logic [`SRAMC_CNT_W-1:0]       cnt_q;          // Phase cycle counter
	logic [`SRAMC_DATA_W-1:0]      din_meta_q;     // First sync stage
	logic [`SRAMC_DATA_W-1:0]      din_sync_q;     // Second sync stage
	logic                          cnt_zero;       // Current phase on its last cycle
	logic                          win_next;       // Strobe low and pins driven next cycle
	logic                          rd_last;        // Last cycle of a read

	// Counter load value as a sized count
	function automatic logic [`SRAMC_CNT_W-1:0] cyc(input int n);
		cyc = `SRAMC_CNT_W'(n - 1);
	endfunction

	// Write window decode, shared by strobe and pin drive so both move together
	function automatic logic in_window(input sramc_state_e st, input logic last);
		in_window = (st == SRAMC_WTURN && last) || (st == SRAMC_WRITE && !last);
	endfunction

	// Last cycle of the given phase
	function automatic logic phase_end(input sramc_state_e st, input sramc_state_e want, input logic last);
		phase_end = (st == want) && last;
	endfunction

	// Phase decodes used by several processes
	assign cnt_zero = (cnt_q == 8'h00);
	assign win_next = in_window(state_q, cnt_zero);
	assign rd_last  = phase_end(state_q, SRAMC_READ, cnt_zero);

	// Ready only when idle
	assign req_ready = (state_q == SRAMC_IDLE);

	// Pin data passes two flip-flops before use
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Both stages cleared
			din_meta_q <= 4'h0;
			din_sync_q <= 4'h0;
		end else begin
			// Pin level shifts through both stages
			din_meta_q <= shared_data_pins_i;
			din_sync_q <= din_meta_q;
		end
	end

	// Sequencer and counter
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Idle and ready out of reset
			state_q <= SRAMC_IDLE;
			cnt_q   <= 8'h00;
		end else begin
			unique case (state_q)
				SRAMC_IDLE: begin
					// Address applied with strobe high, no setup wait
					if (req_valid) begin
						if (req_write) begin
							state_q <= SRAMC_WTURN;
							cnt_q   <= cyc(`SRAMC_RELEASE_Z_CYC);
						end else begin
							// Read spans access time plus two sync stages
							state_q <= SRAMC_READ;
							cnt_q   <= cyc(`SRAMC_ACCESS_CYC + 2);
						end
					end
				end
				SRAMC_READ: begin
					// Select stays low until the word is through the sync stages
					if (cnt_q == 8'h00) begin
						// Back to idle, data captured on this edge
						state_q <= SRAMC_IDLE;
					end else begin
						// Count the access down
						cnt_q <= cnt_q - 8'h01;
					end
				end
				SRAMC_WTURN: begin
					// Turnaround with strobe high: the device still reads here and lets go
					// of the pins only once the strobe falls
					if (cnt_q == 8'h00) begin
						state_q <= SRAMC_WRITE;
						cnt_q   <= cyc((`SRAMC_WRITE_WIN_CYC > `SRAMC_OVERLAP_CYC) ?
							`SRAMC_WRITE_WIN_CYC : `SRAMC_OVERLAP_CYC);
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				SRAMC_WRITE: begin
					// Window and data overlap both met before strobe rises
					if (cnt_q == 8'h00) begin
						// Strobe rises on this edge, release interval starts
						state_q <= SRAMC_WREL;
						cnt_q   <= cyc(`SRAMC_RELEASE_CYC);
					end else begin
						// Strobe held low
						cnt_q <= cnt_q - 8'h01;
					end
				end
				SRAMC_WREL: begin
					// Address still held for release interval
					if (cnt_q == 8'h00) begin
						// Deselect and complete on this edge
						state_q <= SRAMC_IDLE;
					end else begin
						// Address and select held
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: begin
					// Illegal code recovers to idle
					state_q <= SRAMC_IDLE;
				end
			endcase
		end
	end

	// Address and write data latched on acceptance, stable for the access
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Parked at word zero
			word_addr          <= 10'h000;
			shared_data_pins_o <= 4'h0;
		end else if (req_valid && req_ready) begin
			// Taken only on acceptance, so both stand for the whole access
			word_addr          <= req_addr;
			shared_data_pins_o <= req_wdata;
		end
	end

	// Select low for the whole access, high once the release interval is over
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Deselected out of reset
			select_n <= 1'b1;
		end else begin
			// Low from acceptance, through the window and release interval
			select_n <= !((state_q == SRAMC_IDLE && req_valid) ||
				(state_q == SRAMC_READ && !cnt_zero) ||
				(state_q == SRAMC_WTURN) || (state_q == SRAMC_WRITE) ||
				(state_q == SRAMC_WREL && !cnt_zero));
		end
	end

	// Strobe falls after address is set, rises while address held
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Strobe high out of reset, so nothing is stored
			write_n <= 1'b1;
		end else begin
			// Same decode as the pin drive, so both edges coincide
			write_n <= !win_next;
		end
	end

	// Drive pins only inside the window, data stands through the overlap
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Pins released out of reset
			shared_data_pins_oe <= 1'b0;
		end else begin
			// Driven exactly while the strobe is low
			shared_data_pins_oe <= win_next;
		end
	end

	// Read data captured at end of read, completion pulses
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// Pulses low out of reset
			rsp_valid  <= 1'b0;
			rsp_rdata  <= 4'h0;
			done_pulse <= 1'b0;
		end else begin
			rsp_valid  <= rd_last;
			done_pulse <= rd_last || phase_end(state_q, SRAMC_WREL, cnt_zero);
			if (rd_last) begin
				// Word held until the next read ends
				rsp_rdata <= din_sync_q;
			end
		end
	end

endmodule // sramc_host
`default_nettype wire

// File: sramc_host_monitor.sv
// Pin timing checker for the memory host
`timescale 1ns/1ps
`default_nettype none
module sramc_host_monitor(
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       req_valid,
	input wire logic       req_ready,
	input wire logic       rsp_valid,
	input wire logic       done_pulse,
	input wire logic [9:0] word_addr,
	input wire logic       select_n,
	input wire logic       write_n,
	input wire logic       shared_data_pins_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	AST_ADDR_MOVE: assert property ($changed(word_addr) |-> write_n && $past(write_n))
		else $error("address moved in write");
	AST_DRIVE_WIN: assert property (shared_data_pins_oe |-> !write_n && !select_n)
		else $error("drive outside window");
	AST_STROBE_SEL: assert property (!write_n |-> !select_n)
		else $error("strobe without select");
	AST_WIN_LEN: assert property ($fell(write_n) |-> !write_n[*8] ##12 !write_n ##1 write_n)
		else $error("window length");
	AST_RELEASE: assert property ($rose(write_n) |-> (!select_n && $stable(word_addr))[*4])
		else $error("release too short");
	AST_DONE_ONE: assert property (done_pulse |=> !done_pulse)
		else $error("done too long");
	AST_RSP_DONE: assert property (rsp_valid |-> done_pulse && select_n)
		else $error("data without done");
	AST_SEL_GO: assert property (req_valid && req_ready |=> !select_n)
		else $error("select late");
endmodule // sramc_host_monitor
bind sramc_host sramc_host_monitor sramc_host_monitor_i (.clock(clock), .sys_rst(sys_rst),
	.req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .done_pulse(done_pulse),
	.word_addr(word_addr), .select_n(select_n), .write_n(write_n), .shared_data_pins_oe(shared_data_pins_oe));
`default_nettype wire

// File: sramc_host_test.sv
// Bench for the memory host with a pin-level memory model
`timescale 1ns/1ps
`default_nettype none
`include "sramc_consts.svh"
module sramc_host_test;
	logic       clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
	logic [9:0] req_addr = 10'h000, addr;
	logic [3:0] req_wdata = 4'h0, junk = 4'h0, pins_o, mem_o, rdata;
	logic       oe, mem_oe, ready, rsp, done, sel_n, wr_n;
	wire  [3:0] pins = oe ? pins_o : mem_oe ? mem_o : junk; // Released pins wander
	int         num_errors = 0, tests_run = 0;
	// Edges from acceptance to the completion pulse: access plus two sync stages
	localparam int RD = `SRAMC_ACCESS_CYC + 2;
	// Turnaround, window and release interval
	localparam int WR = `SRAMC_RELEASE_Z_CYC + `SRAMC_WRITE_WIN_CYC + `SRAMC_RELEASE_CYC;
	logic [9:0] at [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
	logic [3:0] dt [4] = '{4'h5, 4'ha, 4'hf, 4'h0};
	sramc_host sramc_host_i (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(ready),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp), .rsp_rdata(rdata),
		.done_pulse(done), .word_addr(addr), .select_n(sel_n), .write_n(wr_n), .shared_data_pins_i(pins),
		.shared_data_pins_o(pins_o), .shared_data_pins_oe(oe));
	sramc_mem_model sramc_mem_model_i (.word_addr(addr), .select_n(sel_n), .write_n(wr_n), .pins_in(pins),
		.pins_out(mem_o), .pins_oe(mem_oe));
	initial forever #2.5 clock = ~clock;
	always @(posedge clock) junk <= junk + 4'h3;
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One access: hand over, time the completion, judge the answer
	task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] d, input int lat);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		check(10'(ready), 10'h001);
		@(posedge clock) #1;
		req_valid = 1'b0;
		while (done !== 1'b1) begin
			if (++n > 99) begin num_errors++; finish_test(); end
			@(posedge clock) #1;
		end
		check(n[9:0], 10'(lat));
		check(10'(rsp), 10'(!w));
		if (!w) check(10'(rdata), 10'(d));
	endtask
	// Both ends and opposite patterns, written then read back to back
	task automatic scen_fill();
		for (int i = 0; i < 4; i++) xfer(1, at[i], dt[i], WR);
		for (int i = 0; i < 4; i++) xfer(0, at[i], dt[i], RD);
	endtask
	// Long idle, then every word read twice
	task automatic scen_hold();
		repeat (300) @(posedge clock);
		#1;
		for (int i = 7; i >= 0; i--) xfer(0, at[i/2], dt[i/2], RD);
	endtask
	// Reset during write turnaround: pins back to idle, old word untouched
	task automatic scen_abort();
		req_valid = 1'b1;
		req_write = 1'b1;
		req_addr = at[0];
		req_wdata = ~dt[0];
		@(posedge clock) #1;
		req_valid = 1'b0;
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge clock);
		#1 sys_rst = 1'b0;
		check(10'({sel_n, wr_n, oe, ready}), 10'h00d);
		xfer(0, at[0], dt[0], RD);
	endtask
	initial begin
		repeat (8) @(posedge clock);
		#1 sys_rst = 0;
		scen_fill();
		scen_hold();
		scen_abort();
		finish_test();
	end
endmodule // sramc_host_test
`default_nettype wire

// File: sramc_mem_model.sv
// Pin-level 1K by 4 static memory
`timescale 1ns/1ps
`default_nettype none
module sramc_mem_model(
	input wire logic [9:0] word_addr,
	input wire logic       select_n,
	input wire logic       write_n,
	input wire logic [3:0] pins_in,
	output logic     [3:0] pins_out,
	output logic           pins_oe
);
	logic [3:0] mem_q [1024]; // Word store, kept without refresh
	// Drive only while selected and not writing
	assign pins_oe = !select_n && write_n;
	assign pins_out = mem_q[word_addr]; // Full decode, same polarity
	// Store only in the overlap of select and strobe low
	always @(word_addr, select_n, write_n, pins_in) if (!select_n && !write_n) mem_q[word_addr] = pins_in;
endmodule // sramc_mem_model
`default_nettype wire

// File: sramc_pkg.sv
// Types for the static memory host controller
`default_nettype none
package sramc_pkg;
	typedef enum logic [4:0] {
		SRAMC_IDLE  = 5'h01,
		SRAMC_READ  = 5'h02,
		SRAMC_WTURN = 5'h04,
		SRAMC_WRITE = 5'h08,
		SRAMC_WREL  = 5'h10
	} sramc_state_e;
endpackage
`default_nettype wire
